// ### nce_cfg.svh
`ifndef NCE_CFG_SVH
`define NCE_CFG_SVH

// ************************************************************
// instruction word fields
// ************************************************************
`define NCE_OPC_MSB   15
`define NCE_OPC_LSB   11
`define NCE_SEL_BIT   10
`define NCE_FLD_MSB   10
`define NCE_FLD_LSB   7
`define NCE_BANK_MSB  9
`define NCE_BANK_LSB  7
`define NCE_ADDR_MSB  6
`define NCE_TGT_MSB   10
`define NCE_JMP_MSB   11
`define NCE_HI_MSB    7
`define NCE_HI_LSB    4
`define NCE_LO_MSB    3

// ************************************************************
// opcode values
// ************************************************************
`define NCE_OPC_ADC   5'h00
`define NCE_OPC_ADD   5'h01
`define NCE_OPC_SBC   5'h02
`define NCE_OPC_SUB   5'h03
`define NCE_OPC_EOR   5'h04
`define NCE_OPC_OR    5'h05
`define NCE_OPC_AND   5'h06
`define NCE_OPC_LDST  5'h07
`define NCE_OPC_ADI   5'h08
`define NCE_OPC_ADIM  5'h09
`define NCE_OPC_SBI   5'h0a
`define NCE_OPC_SBIM  5'h0b
`define NCE_OPC_EORIM 5'h0c
`define NCE_OPC_ORIM  5'h0d
`define NCE_OPC_ANDIM 5'h0e
`define NCE_OPC_LDI   5'h0f
`define NCE_OPC_BNZ   5'h10
`define NCE_OPC_BNC   5'h11
`define NCE_OPC_BAZ   5'h12
`define NCE_OPC_BC    5'h13
`define NCE_OPC_BA0   5'h14
`define NCE_OPC_BA1   5'h15
`define NCE_OPC_BA2   5'h16
`define NCE_OPC_BA3   5'h17
`define NCE_OPC_CALL  5'h18
`define NCE_OPC_DEC   5'h19
`define NCE_OPC_RTN   5'h1a
`define NCE_OPC_JMP0  5'h1c
`define NCE_OPC_JMP1  5'h1d
`define NCE_OPC_SPEC  5'h1e
`define NCE_FLD_DAA   4'h6
`define NCE_FLD_DAS   4'ha
`define NCE_RTNW_PFX  3'h0
`define NCE_WORD_SHR  16'hf000
`define NCE_WORD_TABLE_JUMP_OP 16'hf7ff

// ************************************************************
// reset values and decimal constants
// ************************************************************
`define NCE_PC_RST    12'h000
`define NCE_NIB_RST   4'h0
`define NCE_BIT_RST   1'h0
`define NCE_BANK_ZERO 3'h0
`define NCE_BCD_MAX   4'h9
`define NCE_ADJ_ADD   4'h6
`define NCE_ADJ_SUB   4'ha

`endif

// ### nce_pkg.sv
package nce_pkg;
  // alu operation select
  typedef enum logic [3:0] {
    alu_add,
    alu_sub,
    alu_eor,
    alu_or,
    alu_and,
    alu_pass,
    alu_shr,
    alu_daa,
    alu_das
  } nce_alu_op_e;
endpackage : nce_pkg

// ### nce_alu_if.sv
interface nce_alu_if;
  import nce_pkg::*;
  nce_alu_op_e op;
  logic [3:0]  a;
  logic [3:0]  b;
  logic        cin;
  logic [3:0]  res;
  logic        cout;
  modport alu (input op, a, b, cin, output res, cout);
  modport ctl (output op, a, b, cin, input res, cout);
endinterface : nce_alu_if

// ### nce_alu.sv
`include "nce_cfg.svh"

module nce_alu
(
  nce_alu_if.alu bus
);
  import nce_pkg::*;

  logic [4:0] sum;

  // ************************************************************
  // nibble arithmetic and logic
  // ************************************************************
  always_comb
  begin
    sum      = 5'h00;
    bus.res  = 4'h0;
    bus.cout = bus.cin;
    unique case (bus.op)
      alu_add:
      begin
        sum      = {1'b0, bus.a} + {1'b0, bus.b} + {4'h0, bus.cin};
        bus.res  = sum[3:0];
        bus.cout = sum[4];
      end
      // carry out set means no borrow
      alu_sub:
      begin
        sum      = {1'b0, bus.a} + {1'b0, ~bus.b} + {4'h0, bus.cin};
        bus.res  = sum[3:0];
        bus.cout = sum[4];
      end
      alu_eor:  bus.res = bus.a ^ bus.b;
      alu_or:   bus.res = bus.a | bus.b;
      alu_and:  bus.res = bus.a & bus.b;
      alu_pass: bus.res = bus.b;
      alu_shr:
      begin
        bus.res  = {1'b0, bus.a[3:1]};
        bus.cout = bus.a[0];
      end
      // add six when digit overflowed
      alu_daa:
      begin
        if (bus.cin || (bus.a > `NCE_BCD_MAX))
        begin
          bus.res  = bus.a + `NCE_ADJ_ADD;
          bus.cout = 1'b1;
        end
        else
          bus.res  = bus.a;
      end
      // subtract six when a borrow occurred
      alu_das:
      begin
        if (!bus.cin || (bus.a > `NCE_BCD_MAX))
        begin
          bus.res  = bus.a + `NCE_ADJ_SUB;
          bus.cout = 1'b0;
        end
        else
          bus.res  = bus.a;
      end
    endcase
  end
endmodule : nce_alu

// ### nce_exec.sv
// Function
// - one word, one cycle per instruction
// - add with carry to accumulator and memory
// - subtract adds complement plus one or carry
// - one opcode bit selects memory write
// - shift right, zero in, bit0 to carry
// - decimal fix after add, writes both
// - decimal fix after sub, writes both
// - branch when selected accumulator bit set
// - table jump uses page, table, accumulator
`include "nce_cfg.svh"

module nce_exec
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] inst_word_i,
  input  wire logic [3:0]  mem_rdata_i,
  output logic      [11:0] pc_o,
  output logic      [2:0]  mem_bank_o,
  output logic      [6:0]  mem_addr_o,
  output logic      [3:0]  mem_wdata_o,
  output logic             mem_we_o,
  output logic      [3:0]  accumulator_nibble_o,
  output logic             carry_flag_o,
  output logic      [3:0]  table_branch_reg_o
);
  import nce_pkg::*;

  logic [4:0]  opc;
  logic [3:0]  fld;
  logic [2:0]  rd_bank;
  logic [3:0]  memory_operand;
  logic [11:0] pc_ff, nxt_pc;
  logic [3:0]  acc_ff, nxt_acc;
  logic        cy_ff, nxt_cy;
  logic [3:0]  tbr_ff, nxt_tbr;
  logic        we_ff, nxt_we;
  logic [3:0]  wdat_ff, nxt_wdat;
  logic [6:0]  wadr_ff, nxt_wadr;
  logic [2:0]  wbank_ff, nxt_wbank;
  logic        wr_acc, wr_mem, wr_cy;
  logic [11:0] tgt_page;
  logic        is_logic, is_undef;

  nce_alu_if alu_bus ();

  nce_alu u_alu
  (
    .bus (alu_bus)
  );

  // ************************************************************
  // operand fetch
  // ************************************************************
  assign opc      = inst_word_i[`NCE_OPC_MSB:`NCE_OPC_LSB];
  assign fld      = inst_word_i[`NCE_FLD_MSB:`NCE_FLD_LSB];
  assign tgt_page = {pc_ff[`NCE_JMP_MSB], inst_word_i[`NCE_TGT_MSB:0]};
  // bank field only exists in accumulator-type words
  assign rd_bank  = (opc <= `NCE_OPC_LDST) ?
                    inst_word_i[`NCE_BANK_MSB:`NCE_BANK_LSB] : `NCE_BANK_ZERO;
  // forward a write still pending at the ram
  assign memory_operand = (we_ff && (wbank_ff == rd_bank) &&
                           (wadr_ff == inst_word_i[`NCE_ADDR_MSB:0])) ?
                          wdat_ff : mem_rdata_i;

  // ************************************************************
  // decode and execute
  // ************************************************************
  always_comb
  begin
    alu_bus.op  = alu_pass;
    alu_bus.a   = memory_operand;
    alu_bus.b   = acc_ff;
    alu_bus.cin = cy_ff;
    wr_acc      = 1'b0;
    wr_mem      = 1'b0;
    wr_cy       = 1'b0;
    is_logic    = 1'b0;
    is_undef    = 1'b0;
    nxt_pc      = pc_ff + 12'h001;
    nxt_tbr     = tbr_ff;
    unique case (opc)
      // add with or without carry, optional write back
      `NCE_OPC_ADC, `NCE_OPC_ADD:
      begin
        alu_bus.op  = alu_add;
        alu_bus.cin = (opc == `NCE_OPC_ADC) ? cy_ff : 1'b0;
        wr_acc      = 1'b1;
        wr_cy       = 1'b1;
        // select bit routes result to memory
        wr_mem      = inst_word_i[`NCE_SEL_BIT];
      end
      `NCE_OPC_SBC, `NCE_OPC_SUB:
      begin
        alu_bus.op  = alu_sub;
        alu_bus.cin = (opc == `NCE_OPC_SBC) ? cy_ff : 1'b1;
        wr_acc      = 1'b1;
        wr_cy       = 1'b1;
        wr_mem      = inst_word_i[`NCE_SEL_BIT];
      end
      `NCE_OPC_EOR, `NCE_OPC_OR, `NCE_OPC_AND:
      begin
        alu_bus.op = (opc == `NCE_OPC_EOR) ? alu_eor :
                     (opc == `NCE_OPC_OR)  ? alu_or  : alu_and;
        wr_acc     = 1'b1;
        is_logic   = 1'b1;
        wr_mem     = inst_word_i[`NCE_SEL_BIT];
      end
      // load accumulator or store it
      `NCE_OPC_LDST:
      begin
        alu_bus.b = inst_word_i[`NCE_SEL_BIT] ? acc_ff : memory_operand;
        wr_acc    = !inst_word_i[`NCE_SEL_BIT];
        wr_mem    = inst_word_i[`NCE_SEL_BIT];
      end
      // immediate add and subtract
      `NCE_OPC_ADI, `NCE_OPC_ADIM, `NCE_OPC_SBI, `NCE_OPC_SBIM:
      begin
        alu_bus.op  = opc[1] ? alu_sub : alu_add;
        alu_bus.b   = fld;
        alu_bus.cin = opc[1];
        wr_acc      = 1'b1;
        wr_cy       = 1'b1;
        wr_mem      = opc[0];
      end
      // immediate logic into both
      `NCE_OPC_EORIM, `NCE_OPC_ORIM, `NCE_OPC_ANDIM:
      begin
        alu_bus.op = (opc == `NCE_OPC_EORIM) ? alu_eor :
                     (opc == `NCE_OPC_ORIM)  ? alu_or  : alu_and;
        alu_bus.b  = fld;
        wr_acc     = 1'b1;
        wr_mem     = 1'b1;
        is_logic   = 1'b1;
      end
      `NCE_OPC_LDI:
      begin
        alu_bus.b = fld;
        wr_acc    = 1'b1;
        wr_mem    = 1'b1;
      end
      // zero and carry branches within the page
      `NCE_OPC_BNZ: if (acc_ff != 4'h0) nxt_pc = tgt_page;
      `NCE_OPC_BNC: if (!cy_ff) nxt_pc = tgt_page;
      `NCE_OPC_BAZ: if (acc_ff == 4'h0) nxt_pc = tgt_page;
      `NCE_OPC_BC:  if (cy_ff) nxt_pc = tgt_page;
      `NCE_OPC_BA0, `NCE_OPC_BA1, `NCE_OPC_BA2, `NCE_OPC_BA3:
        if (acc_ff[opc[1:0]]) nxt_pc = tgt_page;
      `NCE_OPC_CALL: nxt_pc = tgt_page;
      `NCE_OPC_DEC:
      begin
        alu_bus.a = acc_ff;
        if ((fld == `NCE_FLD_DAA) || (fld == `NCE_FLD_DAS))
        begin
          alu_bus.op = (fld == `NCE_FLD_DAA) ? alu_daa : alu_das;
          wr_acc     = 1'b1;
          wr_mem     = 1'b1;
          wr_cy      = 1'b1;
        end
        else
          is_undef = 1'b1;
      end
      // return with value loads table and accumulator
      `NCE_OPC_RTN:
      begin
        alu_bus.b = inst_word_i[`NCE_LO_MSB:0];
        if (inst_word_i[`NCE_FLD_MSB:8] == `NCE_RTNW_PFX)
        begin
          wr_acc  = 1'b1;
          nxt_tbr = inst_word_i[`NCE_HI_MSB:`NCE_HI_LSB];
        end
      end
      `NCE_OPC_JMP0, `NCE_OPC_JMP1: nxt_pc = inst_word_i[`NCE_JMP_MSB:0];
      `NCE_OPC_SPEC:
      begin
        alu_bus.a = acc_ff;
        if (inst_word_i == `NCE_WORD_SHR)
        begin
          alu_bus.op = alu_shr;
          wr_acc     = 1'b1;
          wr_cy      = 1'b1;
        end
        // table jump keeps upper page bits
        else if (inst_word_i == `NCE_WORD_TABLE_JUMP_OP)
          nxt_pc = {pc_ff[11:8], tbr_ff, acc_ff};
        else
          is_undef = 1'b1;
      end
      default: is_undef = 1'b1;
    endcase
    nxt_acc   = wr_acc ? alu_bus.res : acc_ff;
    nxt_cy    = wr_cy ? alu_bus.cout : cy_ff;
    nxt_we    = wr_mem;
    nxt_wdat  = wr_mem ? alu_bus.res : wdat_ff;
    nxt_wadr  = wr_mem ? inst_word_i[`NCE_ADDR_MSB:0] : wadr_ff;
    nxt_wbank = wr_mem ? rd_bank : wbank_ff;
  end

  // ************************************************************
  // architectural state
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pc_ff    <= `NCE_PC_RST;
      acc_ff   <= `NCE_NIB_RST;
      cy_ff    <= `NCE_BIT_RST;
      tbr_ff   <= `NCE_NIB_RST;
      we_ff    <= `NCE_BIT_RST;
      wdat_ff  <= `NCE_NIB_RST;
      wadr_ff  <= 7'h00;
      wbank_ff <= `NCE_BANK_ZERO;
    end
    else
    begin
      pc_ff    <= nxt_pc;
      acc_ff   <= nxt_acc;
      cy_ff    <= nxt_cy;
      tbr_ff   <= nxt_tbr;
      we_ff    <= nxt_we;
      wdat_ff  <= nxt_wdat;
      wadr_ff  <= nxt_wadr;
      wbank_ff <= nxt_wbank;
    end
  end

  // outputs straight from the state flops
  assign pc_o                 = pc_ff;
  assign accumulator_nibble_o = acc_ff;
  assign carry_flag_o         = cy_ff;
  assign table_branch_reg_o   = tbr_ff;
  assign mem_we_o             = we_ff;
  assign mem_wdata_o          = wdat_ff;
  assign mem_addr_o           = wadr_ff;
  assign mem_bank_o           = wbank_ff;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  single_cycle_a: assert property (
    (opc == `NCE_OPC_LDST) |=> (pc_ff == $past(pc_ff) + 12'h001))
    else $error("pc did not step after a one-cycle op");

  adc_mem_sum_a: assert property (
    (opc == `NCE_OPC_ADC) && inst_word_i[`NCE_SEL_BIT] |=>
      we_ff && (wdat_ff == acc_ff) &&
      ({cy_ff, acc_ff} == 5'({1'b0, $past(memory_operand)}) +
       5'({1'b0, $past(acc_ff)}) + 5'({4'h0, $past(cy_ff)})))
    else $error("add with carry to memory wrong");

  sub_complement_a: assert property (
    (opc == `NCE_OPC_SUB) |=>
      ({cy_ff, acc_ff} == 5'({1'b0, $past(memory_operand)}) +
       5'({1'b0, ~$past(acc_ff)}) + 5'h01))
    else $error("subtract result wrong");

  acc_only_a: assert property (
    (opc <= `NCE_OPC_AND) && !inst_word_i[`NCE_SEL_BIT] |=> !we_ff)
    else $error("memory written by accumulator-only op");

  shr_result_a: assert property (
    (inst_word_i == `NCE_WORD_SHR) |=>
      (acc_ff == {1'b0, $past(acc_ff[3:1])}) && (cy_ff == $past(acc_ff[0])))
    else $error("shift right wrong");

  daa_fix_a: assert property (
    (opc == `NCE_OPC_DEC) && (fld == `NCE_FLD_DAA) && (acc_ff > `NCE_BCD_MAX) |=>
      cy_ff && we_ff && (acc_ff == $past(acc_ff) + `NCE_ADJ_ADD))
    else $error("decimal adjust after add wrong");

  das_fix_a: assert property (
    (opc == `NCE_OPC_DEC) && (fld == `NCE_FLD_DAS) && !cy_ff |=>
      we_ff && (wdat_ff == acc_ff) && (acc_ff == $past(acc_ff) + `NCE_ADJ_SUB))
    else $error("decimal adjust after sub wrong");

  ba_branch_a: assert property (
    (opc[4:2] == 3'h5) |=>
      (pc_ff == ($past(acc_ff[opc[1:0]]) ? $past(tgt_page) : $past(pc_ff) + 12'h001)))
    else $error("accumulator bit branch wrong");

  table_jump_op_pc_a: assert property (
    (inst_word_i == `NCE_WORD_TABLE_JUMP_OP) |=>
      (pc_ff == {$past(pc_ff[11:8]), $past(tbr_ff), $past(acc_ff)}))
    else $error("table jump target wrong");

  logic_carry_a: assert property (
    is_logic |=> $stable(cy_ff))
    else $error("logical op changed carry");

  undef_nop_a: assert property (
    is_undef |=> $stable(acc_ff) && $stable(cy_ff) && !we_ff &&
      (pc_ff == $past(pc_ff) + 12'h001))
    else $error("undefined opcode changed state");
endmodule : nce_exec

// ### nce_ram_model.sv
module nce_ram_model
(
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] inst_word_i,
  input  wire logic [2:0]  mem_bank_i,
  input  wire logic [6:0]  mem_addr_i,
  input  wire logic [3:0]  mem_wdata_i,
  input  wire logic        mem_we_i,
  output logic      [3:0]  mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // data ram, eight banks of 128 nibbles
  // ****************************************
  logic [3:0] mem [0:1023];
  logic [2:0] rd_bank;
  // read bank follows the opcode class
  assign rd_bank     = (inst_word_i[15:11] <= 5'h07) ? inst_word_i[9:7] : 3'h0;
  assign mem_rdata_o = mem[{rd_bank, inst_word_i[6:0]}];
  // write lands at the edge after the strobe
  always @(posedge sys_clk_i)
  begin
    if (mem_we_i === 1'b1)
      mem[{mem_bank_i, mem_addr_i}] <= mem_wdata_i;
  end
  // all cells start at all ones, so a missed forward shows
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 4'hf;
  end
endmodule : nce_ram_model

// ### test_nibble_cpu_instruction_execute.sv
module test_nibble_cpu_instruction_execute;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // stimulus, checks and verdict
  // ****************************************
  typedef struct packed {
    logic [15:0] w;
    logic [3:0]  m;
    logic [3:0]  a;
    logic [3:0]  ea;
    logic        c;
    logic        ec;
    logic        ewe;
    logic        ej;
  } nce_row_s;
  logic        sys_clk_i;
  logic        reset_n_i;
  logic [15:0] inst_word_i;
  logic [3:0]  mem_rdata_i;
  logic [11:0] pc_o;
  logic [2:0]  mem_bank_o;
  logic [6:0]  mem_addr_o;
  logic [3:0]  mem_wdata_o;
  logic        mem_we_o;
  logic [3:0]  accumulator_nibble_o;
  logic        carry_flag_o;
  logic [3:0]  table_branch_reg_o;
  logic [11:0] epc;
  int          miscompares = 0;
  int          checked = 0;
  // word, mem, acc, expected acc, {carry, exp carry, exp write, exp jump}
  nce_row_s rows [39] = '{
    32'h0085_982c, 32'h0485_348a, 32'h0885_f10c,
    32'h1485_5316, 32'h1885_35e0, 32'h1c85_7256, 32'h5185_20f8,
    32'h2485_a6ce, 32'h2885_96f0, 32'h3485_c64e, 32'h7185_602e,
    32'h3c85_0662, 32'h3885_464c, 32'h4b85_9006, 32'h7a85_005e,
    32'hf000_0524, 32'hf000_0848,
    32'hcb05_0b16, 32'hcb05_039e, 32'hcb05_0442,
    32'hcd05_0712, 32'hcd05_055e, 32'hcd05_0c6a,
    32'hc805_033c, 32'hd800_0770, 32'hf001_099c,
    32'ha123_0111, 32'ha123_0eec, 32'ha923_0221, 32'ha923_0dd0,
    32'hb123_0441, 32'hb123_0bb0, 32'hb923_0881, 32'hb923_0770,
    32'h8123_0111, 32'h8923_0001, 32'h9123_0001, 32'h9923_000d,
    32'hc123_0001
  };

  nce_exec dut
  (
    .sys_clk_i            (sys_clk_i),
    .reset_n_i            (reset_n_i),
    .inst_word_i          (inst_word_i),
    .mem_rdata_i          (mem_rdata_i),
    .pc_o                 (pc_o),
    .mem_bank_o           (mem_bank_o),
    .mem_addr_o           (mem_addr_o),
    .mem_wdata_o          (mem_wdata_o),
    .mem_we_o             (mem_we_o),
    .accumulator_nibble_o (accumulator_nibble_o),
    .carry_flag_o         (carry_flag_o),
    .table_branch_reg_o   (table_branch_reg_o)
  );

  nce_ram_model ram
  (
    .sys_clk_i   (sys_clk_i),
    .inst_word_i (inst_word_i),
    .mem_bank_i  (mem_bank_o),
    .mem_addr_i  (mem_addr_o),
    .mem_wdata_i (mem_wdata_o),
    .mem_we_i    (mem_we_o),
    .mem_rdata_o (mem_rdata_i)
  );

  // value comparison
  task automatic chk_val(input string n, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  // flag comparison
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  // verdict and end of run
  task automatic finish_test;
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // pc, acc, tbr, carry and write strobe cleared while reset is low
  task automatic chk_rst;
    chk_val("pc", 12'h000, pc_o);
    chk_val("acc", 12'h000, {8'h00, accumulator_nibble_o});
    chk_val("tbr", 12'h000, {8'h00, table_branch_reg_o});
    chk_bit("carry", 1'b0, carry_flag_o);
    chk_bit("we", 1'b0, mem_we_o);
  endtask : chk_rst

  // one word per edge, entered and left at a falling edge
  task automatic step(input logic [15:0] w, input logic j, input logic [11:0] t);
    inst_word_i = w;
    @(posedge sys_clk_i);
    #1;
    epc = j ? t : epc + 12'h001;
    chk_val("pc", epc, pc_o);
    @(negedge sys_clk_i);
  endtask : step

  // machine cycle clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // hang guard
  initial
  begin
    repeat (2000) @(posedge sys_clk_i);
    miscompares++;
    finish_test();
  end

  initial
  begin
    nce_row_s r;
    reset_n_i   = 1'b0;
    inst_word_i = 16'hffff;
    epc         = 12'h000;
    repeat (8) @(negedge sys_clk_i);
    chk_rst();
    reset_n_i = 1'b1;
    // table rows: carry via shift, acc via load, then the word
    for (int i = 0; i < 39; i++)
    begin
      r = rows[i];
      step({5'h0f, 3'h0, r.c, 7'h7f}, 1'b0, 12'h000);
      step(16'hf000, 1'b0, 12'h000);
      step({5'h0f, r.a, 7'h7f}, 1'b0, 12'h000);
      ram.mem[{((r.w[15:11] <= 5'h07) ? r.w[9:7] : 3'h0), 7'h05}] = r.m;
      step(r.w, r.ej, {epc[11], r.w[10:0]});
      chk_val("acc", {8'h00, r.ea}, {8'h00, accumulator_nibble_o});
      chk_bit("carry", r.ec, carry_flag_o);
      chk_bit("we", r.ewe, mem_we_o);
      if (r.ewe)
      begin
        chk_val("wdata", {8'h00, r.ea}, {8'h00, mem_wdata_o});
        chk_val("addr", 12'h005, {5'h00, mem_addr_o});
        chk_val("bank", {9'h000, r.w[15:11] <= 5'h07 ? r.w[9:7] : 3'h0},
                {9'h000, mem_bank_o});
      end
    end
    // write then read back to back
    ram.mem[{3'h0, 7'h10}] = 4'hf;
    step(16'h7990, 1'b0, 12'h000);
    step(16'h0810, 1'b0, 12'h000);
    chk_val("acc", 12'h006, {8'h00, accumulator_nibble_o});
    chk_bit("carry", 1'b0, carry_flag_o);
    step(16'he5a0, 1'b1, 12'h5a0);
    step(16'hd039, 1'b0, 12'h000);
    chk_val("tbr", 12'h003, {8'h00, table_branch_reg_o});
    chk_val("acc", 12'h009, {8'h00, accumulator_nibble_o});
    step(16'hf7ff, 1'b1, 12'h539);
    // reset again in mid run, then restart from zero
    reset_n_i = 1'b0;
    #1;
    chk_rst();
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    epc       = 12'h000;
    step(16'hffff, 1'b0, 12'h000);
    chk_val("acc", 12'h000, {8'h00, accumulator_nibble_o});
    chk_bit("we", 1'b0, mem_we_o);
    finish_test();
  end
endmodule : test_nibble_cpu_instruction_execute
